// >>> logic/ppfd_apb_port.sv
`timescale 1ns/1ps
module ppfd_apb_port
  import ppfd_pkg::*;
(
  input wire ppfd_apb_req_type req,
  output logic setup,
  output logic wrEn,
  output logic mapped,
  output ppfd_sel_type sel
);

  // ------------------------------------------------------------
  // decode on the word index; top two index bits fall off
  // ------------------------------------------------------------
  logic [29:0] idx;

  assign idx = req.paddr[31:2];
  assign setup = req.psel & ~req.penable;
  assign wrEn = req.psel & req.penable & req.pwrite & mapped;

  always_comb begin
    mapped = 1'b1;
    sel = SEL_PA_DATA;
    if (idx == PA_DATA_IDX[29:0]) begin
      sel = SEL_PA_DATA;
    end else if (idx == PE_DIR_IDX[29:0]) begin
      sel = SEL_PE_DIR;
    end else if (idx == PE_FUNC_IDX[29:0]) begin
      sel = SEL_PE_FUNC;
    end else if (idx == PD_MODE_IDX[29:0]) begin
      sel = SEL_PD_MODE;
    end else begin
      mapped = 1'b0;
    end
  end

endmodule

// >>> logic/ppfd_pin_mux.sv
`timescale 1ns/1ps
module ppfd_pin_mux (
  input wire logic altSel,
  input wire logic genOut,
  input wire logic genOe,
  input wire logic altOut,
  input wire logic altOe,
  output logic pinOut,
  output logic pinOe
);

  // one pin: general path or alternate function
  assign pinOut = altSel ? altOut : genOut;
  assign pinOe = altSel ? altOe : genOe;

endmodule

// >>> logic/ppfd_pkg.sv
package ppfd_pkg;

  // ------------------------------------------------------------
  // register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [31:0] PA_DATA_IDX = 32'hffff8382;
  localparam logic [31:0] PE_DIR_IDX = 32'hffff8384;
  localparam logic [31:0] PE_FUNC_IDX = 32'hffff8386;
  localparam logic [31:0] PD_MODE_IDX = 32'hffff8388;

  // ------------------------------------------------------------
  // writable bit masks and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] PA_DATA_MASK = 16'hdfff;
  localparam logic [15:0] PE_DIR_MASK = 16'h7ff5;
  localparam logic [15:0] PE_FUNC_MASK = 16'h5511;
  localparam logic [15:0] PD_MODE_MASK = 16'h0001;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ------------------------------------------------------------
  // function-select bit of each timer pin, and the port D mode bit
  // ------------------------------------------------------------
  localparam int FN_PIN7 = 14;
  localparam int FN_PIN6 = 12;
  localparam int FN_PIN5 = 10;
  localparam int FN_PIN4 = 8;
  localparam int FN_PIN2 = 4;
  localparam int FN_PIN0 = 0;
  localparam int PD_MODE_BIT = 0;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } ppfd_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ppfd_apb_rsp_type;

  typedef struct packed {
    logic ch2CaptureB;
    logic ch2CaptureA;
    logic ch1CaptureB;
    logic ch1CaptureA;
    logic ch0CaptureC;
    logic ch0CaptureA;
  } ppfd_timer_type;

  typedef enum logic [1:0] {
    SEL_PA_DATA,
    SEL_PE_DIR,
    SEL_PE_FUNC,
    SEL_PD_MODE
  } ppfd_sel_type;

endpackage

// >>> logic/ppfd_port_pins.sv
// Function
// (RULE1) port E direction 1 drives, 0 inputs
// (RULE2) port E direction ignored in other functions; here the timer function also takes its output enable from it
// (RULE3) port E direction bits 15,3,1 read zero
// (RULE4) port E direction cleared by power-on reset only
// (RULE5) port E function cleared by power-on reset only
// (RULE6) function bit 14 selects pin7 timer ch2 B
// (RULE7) function bit 12 selects pin6 timer ch2 A
// (RULE8) function bit 10 selects pin5 timer ch1 B
// (RULE9) function bit 8 selects pin4 timer ch1 A
// (RULE10) function bit 4 selects pin2 timer ch0 C
// (RULE11) function bit 0 selects pin0 timer ch0 A
// (RULE12) reserved function bits read zero, write zero
// (RULE13) port D mode bit routes pin0 to bus
// (RULE14) port A general output drives stored bit
// (RULE15) port A general input reads pin level
// (RULE16) port A input alternate: read pin, store
// (RULE17) port A output alternate: read stored bit
// (RULE18) port A data cleared by power-on reset only
// (RULE19) port A data at its address, byte lanes
// (RULE20) timer pin output comes from timer channel
`timescale 1ns/1ps
module ppfd_port_pins
  import ppfd_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire ppfd_apb_req_type apbReq,
  output ppfd_apb_rsp_type apbRsp,
  input wire logic [15:0] paDirection,
  input wire logic [15:0] paGeneral,
  input wire logic [15:0] paAltOut,
  input wire logic [15:0] paAltOe,
  input wire logic [15:0] paIn,
  output logic [15:0] paOut,
  output logic [15:0] paOe,
  input wire logic [15:0] peGenOut,
  input wire logic [15:0] peIn,
  output logic [15:0] peOut,
  output logic [15:0] peOe,
  input wire ppfd_timer_type timerOut,
  output ppfd_timer_type timerIn,
  input wire logic pdGenOut,
  input wire logic pdGenOe,
  input wire logic busD0Out,
  input wire logic busD0Oe,
  input wire logic pdIn,
  output logic pd0Out,
  output logic pd0Oe,
  output logic busD0In,
  output logic pdModeBus
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] paData;
    logic [15:0] peDir;
    logic [15:0] peFunc;
    logic [15:0] pdMode;
    logic [31:0] rdData;
    logic rdErr;
  } ppfd_state_type;

  ppfd_state_type st_r;
  ppfd_state_type st_nxt;

  logic setup;
  logic wrEn;
  logic mapped;
  ppfd_sel_type sel;
  logic [15:0] paView;
  logic [15:0] wrMerged;
  logic [15:0] regOld;
  logic [15:0] regRead;
  logic [15:0] peAltSel;
  logic [15:0] peAltOut;
  logic [15:0] peGenOe;
  logic [15:0] peAltOe;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  ppfd_apb_port apbPort (
    .req(apbReq),
    .setup(setup),
    .wrEn(wrEn),
    .mapped(mapped),
    .sel(sel)
  );

  // ------------------------------------------------------------
  // port A read view
  // ------------------------------------------------------------
  // direction alone picks pin or storage, function is irrelevant
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (paDirection[i]) begin
        paView[i] = st_r.paData[i]; // [RULE14] [RULE17]
      end else begin
        paView[i] = paIn[i]; // [RULE15] [RULE16]
      end
    end
    paView = paView & PA_DATA_MASK;
  end

  // ------------------------------------------------------------
  // register select, read and byte-lane merge
  // ------------------------------------------------------------
  always_comb begin
    regOld = st_r.paData;
    regRead = paView;
    unique case (sel)
      SEL_PA_DATA: begin
        regOld = st_r.paData;
        regRead = paView;
      end
      SEL_PE_DIR: begin
        regOld = st_r.peDir;
        regRead = st_r.peDir & PE_DIR_MASK; // [RULE3]
      end
      SEL_PE_FUNC: begin
        regOld = st_r.peFunc;
        regRead = st_r.peFunc & PE_FUNC_MASK; // [RULE12]
      end
      SEL_PD_MODE: begin
        regOld = st_r.pdMode;
        regRead = st_r.pdMode & PD_MODE_MASK;
      end
    endcase
  end

  // 8- and 16-bit accesses arrive as lane strobes
  always_comb begin
    wrMerged = regOld;
    if (apbReq.pstrb[0]) begin
      wrMerged[7:0] = apbReq.pwdata[7:0]; // [RULE19]
    end
    if (apbReq.pstrb[1]) begin
      wrMerged[15:8] = apbReq.pwdata[15:8]; // [RULE19]
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // read data captured in setup so that prdata is a flop
    if (setup) begin
      st_nxt.rdData = {16'h0000, regRead};
      st_nxt.rdErr = ~mapped;
      if (!mapped || apbReq.pwrite) begin
        st_nxt.rdData = 32'h00000000;
      end
    end
    if (wrEn) begin
      unique case (sel)
        SEL_PA_DATA: begin
          // storage always updates; pin only follows if general output
          st_nxt.paData = wrMerged & PA_DATA_MASK; // [RULE15] [RULE16] [RULE17]
        end
        SEL_PE_DIR: begin
          st_nxt.peDir = wrMerged & PE_DIR_MASK; // [RULE3]
        end
        SEL_PE_FUNC: begin
          // reserved bits are not stored even if software sets them
          st_nxt.peFunc = wrMerged & PE_FUNC_MASK; // [RULE12]
        end
        SEL_PD_MODE: begin
          st_nxt.pdMode = wrMerged & PD_MODE_MASK;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // srst is the external power-on reset; watchdog reset,
  // standby and sleep never reach this block, so data is kept
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r.paData <= REG_RESET; // [RULE18] [RULE19]
      st_r.peDir <= REG_RESET; // [RULE4]
      st_r.peFunc <= REG_RESET; // [RULE5]
      st_r.pdMode <= REG_RESET; // [RULE13]
      st_r.rdData <= 32'h00000000;
      st_r.rdErr <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------
  // zero wait states: access phase always completes at once
  assign apbRsp.prdata = st_r.rdData;
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = st_r.rdErr & apbReq.psel & apbReq.penable;

  // ------------------------------------------------------------
  // port A pins
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : genPa
      ppfd_pin_mux paMux (
        .altSel(~paGeneral[g]),
        .genOut(st_r.paData[g]), // [RULE14]
        .genOe(paDirection[g] & PA_DATA_MASK[g]), // [RULE14] [RULE15]
        .altOut(paAltOut[g]), // [RULE16] [RULE17]
        .altOe(paAltOe[g]),
        .pinOut(paOut[g]),
        .pinOe(paOe[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // port E function select
  // ------------------------------------------------------------
  always_comb begin
    peAltSel = 16'h0000;
    peAltOut = 16'h0000;
    peAltSel[7] = st_r.peFunc[FN_PIN7]; // [RULE6]
    peAltSel[6] = st_r.peFunc[FN_PIN6]; // [RULE7]
    peAltSel[5] = st_r.peFunc[FN_PIN5]; // [RULE8]
    peAltSel[4] = st_r.peFunc[FN_PIN4]; // [RULE9]
    peAltSel[2] = st_r.peFunc[FN_PIN2]; // [RULE10]
    peAltSel[0] = st_r.peFunc[FN_PIN0]; // [RULE11]
    peAltOut[7] = timerOut.ch2CaptureB; // [RULE20]
    peAltOut[6] = timerOut.ch2CaptureA; // [RULE20]
    peAltOut[5] = timerOut.ch1CaptureB; // [RULE20]
    peAltOut[4] = timerOut.ch1CaptureA; // [RULE20]
    peAltOut[2] = timerOut.ch0CaptureC; // [RULE20]
    peAltOut[0] = timerOut.ch0CaptureA; // [RULE20]
  end

  // both general and timer functions use the direction bit;
  // pins with no direction bit never drive
  assign peGenOe = st_r.peDir & PE_DIR_MASK; // [RULE1] [RULE2]
  assign peAltOe = st_r.peDir & PE_DIR_MASK; // [RULE1] [RULE20]

  // ------------------------------------------------------------
  // port E pins
  // ------------------------------------------------------------
  generate
    for (g = 0; g < 16; g++) begin : genPe
      ppfd_pin_mux peMux (
        .altSel(peAltSel[g]),
        .genOut(peGenOut[g]),
        .genOe(peGenOe[g]), // [RULE1]
        .altOut(peAltOut[g]),
        .altOe(peAltOe[g]), // [RULE1]
        .pinOut(peOut[g]),
        .pinOe(peOe[g])
      );
    end
  endgenerate

  // capture inputs see the pin whatever the direction
  assign timerIn.ch2CaptureB = peIn[7];
  assign timerIn.ch2CaptureA = peIn[6];
  assign timerIn.ch1CaptureB = peIn[5];
  assign timerIn.ch1CaptureA = peIn[4];
  assign timerIn.ch0CaptureC = peIn[2];
  assign timerIn.ch0CaptureA = peIn[0];

  // ------------------------------------------------------------
  // port D pin 0
  // ------------------------------------------------------------
  ppfd_pin_mux pdMux (
    .altSel(st_r.pdMode[PD_MODE_BIT]), // [RULE13]
    .genOut(pdGenOut),
    .genOe(pdGenOe),
    .altOut(busD0Out), // [RULE13]
    .altOe(busD0Oe),
    .pinOut(pd0Out),
    .pinOe(pd0Oe)
  );

  assign busD0In = pdIn;
  assign pdModeBus = st_r.pdMode[PD_MODE_BIT];

endmodule

// >>> test/ppfd_pin_model.sv
`timescale 1ns/1ps
module ppfd_pin_model (
  input wire logic [15:0] paOut,
  input wire logic [15:0] paOe,
  input wire logic [15:0] paExt,
  output logic [15:0] paIn,
  input wire logic [15:0] peOut,
  input wire logic [15:0] peOe,
  input wire logic [15:0] peExt,
  output logic [15:0] peIn,
  input wire logic pd0Out,
  input wire logic pd0Oe,
  input wire logic pdExt,
  output logic pdIn
);
  // undriven pins take the outside level, so reads can tell pin from store
  assign paIn = (paOut & paOe) | (paExt & ~paOe);
  assign peIn = (peOut & peOe) | (peExt & ~peOe);
  assign pdIn = pd0Oe ? pd0Out : pdExt;
endmodule

// >>> test/ppfd_port_pins_monitor.sv
`timescale 1ns/1ps
module ppfd_port_pins_monitor
  import ppfd_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire ppfd_apb_req_type apbReq,
  input wire ppfd_apb_rsp_type apbRsp,
  input wire logic [15:0] paDirection,
  input wire logic [15:0] paGeneral,
  input wire logic [15:0] paIn,
  input wire logic [15:0] paOut,
  input wire logic [15:0] peGenOut,
  input wire logic [15:0] peOut,
  input wire logic [15:0] peOe,
  input wire logic [15:0] peIn,
  input wire ppfd_timer_type timerIn,
  input wire logic pdIn,
  input wire logic busD0In
);
  localparam logic [31:0] A_PA = {PA_DATA_IDX[29:0], 2'b00};
  localparam logic [31:0] A_DIR = {PE_DIR_IDX[29:0], 2'b00};
  localparam logic [31:0] A_FN = {PE_FUNC_IDX[29:0], 2'b00};
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // ----------------
  // bus phases
  // ----------------
  sequence s_rd(logic [31:0] a);
    apbReq.psel && !apbReq.penable && !apbReq.pwrite && apbReq.paddr == a;
  endsequence
  sequence s_wrPa;
    apbReq.psel && apbReq.penable && apbReq.pwrite && apbReq.paddr == A_PA
      && apbReq.pstrb[1:0] == 2'b11;
  endsequence
  property p_resetClear;
    $past(srst) |-> peOe == 16'h0000 && (paOut & paGeneral) == 16'h0000;
  endproperty
  a_resetClear: assert property (p_resetClear) else $error("state not clear");
  property p_dirHoles;
    (peOe & 16'h800a) == 16'h0000;
  endproperty
  a_dirHoles: assert property (p_dirHoles) else $error("hole pin driven");
  property p_dirRead;
    s_rd(A_DIR) |=> (apbRsp.prdata[15:0] & 16'h800a) == 16'h0000;
  endproperty
  a_dirRead: assert property (p_dirRead) else $error("dir hole reads one");
  property p_fnRead;
    s_rd(A_FN) |=> (apbRsp.prdata[15:0] & 16'haaee) == 16'h0000;
  endproperty
  a_fnRead: assert property (p_fnRead) else $error("reserved reads one");
  property p_paRead;
    s_rd(A_PA) |=> ((apbRsp.prdata[15:0] ^ $past(paIn)) & ~$past(paDirection)
      & 16'hdfff) == 16'h0000;
  endproperty
  a_paRead: assert property (p_paRead) else $error("input read not pin");
  property p_paWrite;
    s_wrPa |=> ((paOut ^ $past(apbReq.pwdata[15:0])) & paGeneral & paDirection
      & 16'hdfff) == 16'h0000;
  endproperty
  a_paWrite: assert property (p_paWrite) else $error("output not written");
  property p_timerIn;
    timerIn == {peIn[7:4], peIn[2], peIn[0]};
  endproperty
  a_timerIn: assert property (p_timerIn) else $error("timer input wrong");
  property p_peGen;
    ((peOut ^ peGenOut) & peOe & 16'h7f00) == 16'h0000;
  endproperty
  a_peGen: assert property (p_peGen) else $error("general out wrong");
  property p_busIn;
    busD0In == pdIn;
  endproperty
  a_busIn: assert property (p_busIn) else $error("bus input wrong");
endmodule

// >>> test/ppfd_port_pins_tb.sv
`timescale 1ns/1ps
module ppfd_port_pins_tb
  import ppfd_pkg::*;
;
  localparam logic [31:0] A_PA = {PA_DATA_IDX[29:0], 2'b00};
  localparam logic [31:0] A_DIR = {PE_DIR_IDX[29:0], 2'b00};
  localparam logic [31:0] A_FN = {PE_FUNC_IDX[29:0], 2'b00};
  localparam logic [31:0] A_PD = {PD_MODE_IDX[29:0], 2'b00};
  logic clock = 1'b0;
  logic srst = 1'b1;
  ppfd_apb_req_type req = '0;
  ppfd_apb_rsp_type rsp;
  ppfd_timer_type tmr = '0;
  ppfd_timer_type tIn;
  logic [15:0] paDir = 16'hffff, paGen = 16'hffff, paAlt = 16'h5a5a, paExt = 16'h3c3c;
  logic [15:0] peGen = 16'h1234, peExt = 16'h0f0f;
  logic [15:0] paIn, paOut, paOe, peIn, peOut, peOe;
  logic pdGo = 1'b1, pdGe = 1'b1, bOut = 1'b0, bOe = 1'b0, pdExt = 1'b0;
  logic pdIn, pd0Out, pd0Oe, bIn, pdMode;
  int failCount = 0;
  int nCompared = 0;
  logic lastErr = 1'b0;
  ppfd_port_pins uut (.clock(clock), .srst(srst), .apbReq(req), .apbRsp(rsp),
    .paDirection(paDir), .paGeneral(paGen), .paAltOut(paAlt), .paAltOe(16'h0000),
    .paIn(paIn), .paOut(paOut), .paOe(paOe), .peGenOut(peGen), .peIn(peIn),
    .peOut(peOut), .peOe(peOe), .timerOut(tmr), .timerIn(tIn), .pdGenOut(pdGo),
    .pdGenOe(pdGe), .busD0Out(bOut), .busD0Oe(bOe), .pdIn(pdIn), .pd0Out(pd0Out),
    .pd0Oe(pd0Oe), .busD0In(bIn), .pdModeBus(pdMode));
  ppfd_pin_model pins (.paOut(paOut), .paOe(paOe), .paExt(paExt), .paIn(paIn),
    .peOut(peOut), .peOe(peOe), .peExt(peExt), .peIn(peIn), .pd0Out(pd0Out),
    .pd0Oe(pd0Oe), .pdExt(pdExt), .pdIn(pdIn));
  initial begin
    forever #5 clock = ~clock;
  end
  // ----------------
  // shared tasks
  // ----------------
  task finalReport;
    $display("compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      failCount++;
    end
  endtask
  // waits for pready, never a fixed count
  task xfer(input logic [31:0] a, input logic w, input logic [15:0] d, input logic [3:0] s,
      output logic [15:0] r);
    int i;
    @(posedge clock);
    req <= '{a, 1'b1, 1'b0, w, {16'h0000, d}, s};
    @(posedge clock);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (rsp.pready !== 1'b1 && i < 16);
    if (rsp.pready !== 1'b1) begin
      failCount++;
      finalReport();
    end
    r = rsp.prdata[15:0];
    lastErr = rsp.pslverr;
    req <= '0;
  endtask
  task wr(input logic [31:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
    logic [15:0] r;
    xfer(a, 1'b1, d, s, r);
  endtask
  task rdChk(input logic [31:0] a, input logic [15:0] e);
    logic [15:0] r;
    xfer(a, 1'b0, 16'h0000, 4'h0, r);
    chk(r, e);
  endtask
  task settle;
    @(posedge clock);
    #1;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task tReset;
    rdChk(A_PA, 16'h0000);
    rdChk(A_DIR, 16'h0000);
    rdChk(A_FN, 16'h0000);
    rdChk(A_PD, 16'h0000);
    rdChk(32'hfffe0e30, 16'h0000);
    chk({31'h00000000, lastErr}, 32'h00000001);
    chk({peOe, paOut}, 32'h0);
  endtask
  task tPeDir;
    wr(A_DIR, 16'hffff);
    rdChk(A_DIR, 16'h7ff5);
    settle;
    chk({peOe, peOut & peOe}, {16'h7ff5, peGen & 16'h7ff5});
    wr(A_DIR, 16'h0000);
    settle;
    chk(peOe, 16'h0000);
  endtask
  task tTimer;
    int k;
    wr(A_FN, 16'h5511); // reserved bits kept zero
    rdChk(A_FN, 16'h5511);
    wr(A_DIR, 16'h00f5);
    for (k = 0; k < 2; k++) begin
      @(posedge clock);
      tmr <= k ? 6'h15 : 6'h2a;
      settle;
      chk(peOut & 16'h00f5, {tmr[5:2], 1'b0, tmr[1], 1'b0, tmr[0]});
      chk(peOe, 16'h00f5);
      chk(tIn, {peIn[7:4], peIn[2], peIn[0]});
    end
    wr(A_FN, 16'h0000);
    settle;
    chk(peOut & 16'h00f5, peGen & 16'h00f5);
  endtask
  task tPortD;
    wr(A_PD, 16'hffff);
    rdChk(A_PD, 16'h0001);
    settle;
    chk({pdMode, pd0Out, pd0Oe, bIn}, {3'b100, pdIn});
    wr(A_PD, 16'h0000);
    settle;
    chk({pdMode, pd0Out, pd0Oe}, 3'b011);
  endtask
  task tPortA;
    @(posedge clock);
    paDir <= 16'h00ff;
    paGen <= 16'h0f0f;
    wr(A_PA, 16'ha5a5);
    settle;
    chk({paOut & 16'h00ff, paOe}, {16'h0055, 16'h000f});
    rdChk(A_PA, 16'h1ca5);
    wr(A_PA, 16'hffff, 4'h1);
    rdChk(A_PA, 16'h1cff);
    @(posedge clock);
    paDir <= 16'hffff;
    rdChk(A_PA, 16'h85ff);
    @(posedge clock);
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    rdChk(A_PA, 16'h0000);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    tReset();
    tPeDir();
    tTimer();
    tPortD();
    tPortA();
    finalReport();
  end
endmodule
bind ppfd_port_pins ppfd_port_pins_monitor mon (.clock(clock), .srst(srst),
  .apbReq(apbReq), .apbRsp(apbRsp), .paDirection(paDirection), .paGeneral(paGeneral),
  .paIn(paIn), .paOut(paOut), .peGenOut(peGenOut), .peOut(peOut), .peOe(peOe),
  .peIn(peIn), .timerIn(timerIn), .pdIn(pdIn), .busD0In(busD0In));
